// ==== rtl/pending_status_top.sv ====
// Pending interrupt status, clear, enable-out and pin routing logic
`timescale 1ns/1ps
`include "pending_defs.svh"
module pending_status_top #(
	parameter int NUM_PINS = 4
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic sw_reset,
	input wire logic local_reset,
	input wire pending_pkg::src_event_type events,
	input wire pending_pkg::reg_req_type req,
	output logic [31:0] rdata,
	output logic irq,
	output logic [NUM_PINS-1:0] int_pin_out,
	output logic [NUM_PINS-1:0] int_pin_oe
);
	import pending_pkg::*;

	localparam int MAP_W = `MAP_FIELD_W;
	localparam logic [31:0] VALID = `PENDING_VALID_MASK;

	// ==========================================================
	// Elaboration check: a map field must be able to name every pin
	if (NUM_PINS < 1 || NUM_PINS > (1 << MAP_W)) begin : g_bad_pins
		$error("NUM_PINS must lie between 1 and 4");
	end

	// ==========================================================
	// Event vector from the sources
	logic [31:0] ev_word;
	assign ev_word[31:26] = 6'h00;
	assign ev_word[`BIT_DMA_SECOND] = events.dma_second_pending;
	assign ev_word[`BIT_DMA_FIRST] = events.dma_first_pending;
	assign ev_word[23:20] = {events.locmon_3_pending, events.locmon_2_pending,
		events.locmon_1_pending, events.locmon_0_pending};
	assign ev_word[19:16] = {events.mailbox_3_pending, events.mailbox_2_pending,
		events.mailbox_1_pending, events.mailbox_0_pending};
	assign ev_word[15:14] = 2'h0;
	assign ev_word[`BIT_HOST_ERR] = events.host_bus_error_pending;
	assign ev_word[`BIT_BP_ERR] = events.backplane_error_pending;
	assign ev_word[`BIT_BP_EDGE] = events.backplane_req_edge_pending;
	assign ev_word[`BIT_ACK_CYCLE] = events.acknowledge_cycle_pending;
	assign ev_word[`BIT_SYS_FAIL] = events.system_failure_pending;
	assign ev_word[`BIT_MAINS_FAIL] = events.mains_failure_pending;
	assign ev_word[7:1] = events.level_request_pending;
	assign ev_word[0] = 1'b0;

	// ==========================================================
	// Address decode
	logic hit_enable;
	logic hit_pending;
	logic hit_clear;
	logic hit_map_low;
	logic hit_map_high;
	logic flag_zero;
	logic [31:0] clear_bits;
	assign hit_enable = (req.addr == `OFF_ENABLE_OUT);
	assign hit_pending = (req.addr == `OFF_PENDING);
	assign hit_clear = (req.addr == `OFF_CLEAR);
	assign hit_map_low = (req.addr == `OFF_MAP_LOW);
	assign hit_map_high = (req.addr == `OFF_MAP_HIGH);
	// Software and local reset are same-clock pulses; they share the flag wipe
	assign flag_zero = ~resetn | sw_reset | local_reset;
	assign clear_bits = (req.wr & hit_clear) ? (req.wdata & VALID) : `PENDING_RESET;

	// ==========================================================
	// Pending flags
	logic [31:0] status_word;
	sticky_flags #(
		.WIDTH(32)
	) u_flags (
		.clock(clock),
		.zero(flag_zero),
		.set(ev_word),
		.clear(clear_bits),
		.flags(status_word)
	);

	// ==========================================================
	// Enable-out register, doubles as the interrupt mask
	logic [31:0] enable_r;
	always_ff @(posedge clock) begin
		if (flag_zero) begin
			enable_r <= `PENDING_RESET;
		end else if (req.wr & hit_enable) begin
			enable_r <= req.wdata & VALID;
		end
	end

	// ==========================================================
	// Pin map fields, one per valid source
	logic [31:0][MAP_W-1:0] map_vec;
	logic [31:0] map_low_word;
	logic [31:0] map_high_word;
	assign map_low_word[31:20] = 12'h000;
	assign map_high_word[31:26] = 6'h00;
	for (genvar i = 0; i < 32; i++) begin : g_map
		if (VALID[i]) begin : g_used
			localparam bit LOW = (i >= `MAP_LOW_FIRST);
			localparam int POS = LOW ? MAP_W * (i - `MAP_LOW_FIRST) : MAP_W * (i - `MAP_HIGH_FIRST);
			logic [MAP_W-1:0] map_r;
			logic map_wr;
			assign map_wr = req.wr & (LOW ? hit_map_low : hit_map_high);
			always_ff @(posedge clock) begin
				if (flag_zero) begin
					map_r <= '0;
				end else if (map_wr) begin
					map_r <= req.wdata[POS +: MAP_W];
				end
			end
			assign map_vec[i] = map_r;
			if (LOW) begin : g_low
				assign map_low_word[POS +: MAP_W] = map_r;
			end else begin : g_high
				assign map_high_word[POS +: MAP_W] = map_r;
			end
		end else begin : g_unused
			assign map_vec[i] = '0;
		end
	end

	// ==========================================================
	// Read path; clear and unmapped offsets read zero
	logic [31:0] rd_sel;
	logic [31:0] rdata_r;
	assign rd_sel = hit_pending ? status_word :
		hit_enable ? enable_r :
		hit_map_low ? map_low_word :
		hit_map_high ? map_high_word :
		`PENDING_RESET;
	always_ff @(posedge clock) begin
		if (!resetn) begin
			rdata_r <= `PENDING_RESET;
		end else begin
			rdata_r <= req.rd ? rd_sel : `PENDING_RESET;
		end
	end
	assign rdata = rdata_r;

	// ==========================================================
	// Pin routing: open-drain, so the pin level is always low when enabled
	logic [NUM_PINS-1:0] pin_oe_nxt;
	logic [NUM_PINS-1:0] pin_oe_r;
	logic [31:0] armed;
	logic irq_r;
	assign armed = status_word & enable_r;
	for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
		logic [31:0] route;
		for (genvar i = 0; i < 32; i++) begin : g_src
			assign route[i] = armed[i] & (map_vec[i] == MAP_W'(p));
		end
		assign pin_oe_nxt[p] = |route;
	end
	always_ff @(posedge clock) begin
		if (!resetn) begin
			pin_oe_r <= '0;
			irq_r <= 1'b0;
		end else begin
			pin_oe_r <= pin_oe_nxt;
			irq_r <= |armed;
		end
	end
	assign int_pin_oe = pin_oe_r;
	assign int_pin_out = '0;
	assign irq = irq_r;

endmodule // pending_status_top

// ==== rtl/pending_defs.svh ====
// Register offsets, field positions and reset values of the pending interrupt status block
// Summary of operation
// - The 32-bit pending status word is decoded at configuration offset 0x450.
// - Bit 25 reads one while the second DMA controller interrupt is pending.
// - Bit 24 reads one while the first DMA controller interrupt is pending.
// - Bits 23..20 report location monitors 3..0 pending.
// - Bits 19..16 report mailboxes 3..0 pending.
// - Bit 13 reads one while a host bus error interrupt is pending.
// - Bit 12 reads one while a backplane error interrupt is pending.
// - Bit 11 reads one while a backplane request edge interrupt is pending.
// - Bit 10 reads one while an acknowledge cycle interrupt is pending.
// - Bit 9 reads one while a system failure interrupt is pending.
// - Bit 8 reads one while a mains failure interrupt is pending.
// - Bits 7..1 report backplane request levels 7..1, bit number equals level.
// - Power-up, software or local reset forces every flag to zero.
// - Flags are read-only; writes to the status word change nothing.
// - Writing one to a bit at offset 0x454 clears that flag unless its event sets it in the same cycle; reads zero.
// - A pending source drives its mapped pin only while its enable-out bit is set.
`ifndef PENDING_DEFS_SVH
`define PENDING_DEFS_SVH

// ==========================================================
// Register offsets
`define OFF_ENABLE_OUT 12'h44c
`define OFF_PENDING 12'h450
`define OFF_CLEAR 12'h454
`define OFF_MAP_LOW 12'h458
`define OFF_MAP_HIGH 12'h45c

// ==========================================================
// Field layout and reset values
`define PENDING_RESET 32'h00000000
`define PENDING_VALID_MASK 32'h03ff3ffe
`define MAP_FIELD_W 2
`define MAP_LOW_FIRST 16
`define MAP_HIGH_FIRST 1
`define BIT_DMA_SECOND 25
`define BIT_DMA_FIRST 24
`define BIT_HOST_ERR 13
`define BIT_BP_ERR 12
`define BIT_BP_EDGE 11
`define BIT_ACK_CYCLE 10
`define BIT_SYS_FAIL 9
`define BIT_MAINS_FAIL 8

`endif

// ==== rtl/pending_pkg.sv ====
// Types shared by the pending interrupt status block
package pending_pkg;

	// ==========================================================
	// Source event vector, laid out like the status word
	typedef struct packed {
		logic [5:0] reserved_hi;
		logic dma_second_pending;
		logic dma_first_pending;
		logic locmon_3_pending;
		logic locmon_2_pending;
		logic locmon_1_pending;
		logic locmon_0_pending;
		logic mailbox_3_pending;
		logic mailbox_2_pending;
		logic mailbox_1_pending;
		logic mailbox_0_pending;
		logic [1:0] reserved_mid;
		logic host_bus_error_pending;
		logic backplane_error_pending;
		logic backplane_req_edge_pending;
		logic acknowledge_cycle_pending;
		logic system_failure_pending;
		logic mains_failure_pending;
		logic [7:1] level_request_pending;
		logic reserved_lo;
	} src_event_type;

	// ==========================================================
	// Register port request
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_type;

endpackage

// ==== rtl/sticky_flags.sv ====
// Bank of sticky event flags with write-one clear and set priority
`timescale 1ns/1ps
module sticky_flags #(
	parameter int WIDTH = 32
) (
	input wire logic clock,
	input wire logic zero,
	input wire logic [WIDTH-1:0] set,
	input wire logic [WIDTH-1:0] clear,
	output logic [WIDTH-1:0] flags
);

	// ==========================================================
	// Per-bit flag; a set in the clearing cycle survives
	for (genvar i = 0; i < WIDTH; i++) begin : g_flag
		logic flag_r;
		logic flag_nxt;
		assign flag_nxt = set[i] | (flag_r & ~clear[i]);
		always_ff @(posedge clock) begin
			if (zero) begin
				flag_r <= 1'b0;
			end else begin
				flag_r <= flag_nxt;
			end
		end
		assign flags[i] = flag_r;
	end

endmodule // sticky_flags

// ==== verif/pending_status_sva.sv ====
// Port assertions for the pending status block
`timescale 1ns/1ps
// ==========
// Checker
module pending_status_check #(
	parameter int NUM_PINS = 4
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic sw_reset,
	input wire logic local_reset,
	input wire pending_pkg::src_event_type events,
	input wire pending_pkg::reg_req_type req,
	input wire logic [31:0] rdata,
	input wire logic irq,
	input wire logic [NUM_PINS-1:0] int_pin_out,
	input wire logic [NUM_PINS-1:0] int_pin_oe
);
	import pending_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	wire rd_st = req.rd && req.addr == 12'h450;
	wire calm = !sw_reset && !local_reset;
	a_rdata_idle:
		assert property (!$past(req.rd) |-> rdata == 32'h0) else $error("rdata not zero");
	a_reserved_zero:
		assert property ($past(req.rd && (req.addr == 12'h450 || req.addr == 12'h44c)) |->
			(rdata & 32'hfc00c001) == 32'h0) else $error("reserved bit set");
	a_unmapped_zero:
		assert property ((req.rd && !(req.addr inside {12'h44c, 12'h450, 12'h458, 12'h45c})) |=> rdata == 32'h0)
			else $error("unmapped read not zero");
	a_event_flag:
		assert property ((calm ##1 rd_st) |=> (rdata & $past(events, 2)) == ($past(events, 2) & 32'h03ff3ffe))
			else $error("event flag missing");
	a_clear_flag:
		assert property ((req.wr && req.addr == 12'h454 ##1 rd_st) |=>
			(rdata & $past(req.wdata, 2) & ~$past(events, 2)) == 32'h0) else $error("flag not cleared");
	a_no_drop:
		assert property ((rd_st && calm ##1 calm && !(req.wr && req.addr == 12'h454) ##1 rd_st) |=>
			($past(rdata, 2) & ~rdata) == 32'h0) else $error("flag dropped");
	a_irq_cause:
		assert property ($rose(irq) |-> ($past(events, 2) & 32'h03ff3ffe) != 32'h0 ||
			$past(req.wr && req.addr == 12'h44c, 2)) else $error("irq without cause");
	a_pins_follow:
		assert property ((|int_pin_oe) == irq && int_pin_out == '0) else $error("pins disagree with irq");
	a_soft_reset:
		assert property (((sw_reset || local_reset) ##1 (!req.wr && events == '0)) |=> !irq && int_pin_oe == '0)
			else $error("reset left irq");
endmodule // pending_status_check

bind pending_status_top pending_status_check #(.NUM_PINS(NUM_PINS)) u_pending_status_check (
	.clock(clock), .resetn(resetn), .sw_reset(sw_reset), .local_reset(local_reset), .events(events),
	.req(req), .rdata(rdata), .irq(irq), .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe));

// ==== verif/interrupt_pending_status_test.sv ====
// Self-checking bench for the pending status block
`timescale 1ns/1ps
// ==========
// Bench top
module interrupt_pending_status_test;
	import pending_pkg::*;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic sw_reset = 1'b0;
	logic local_reset = 1'b0;
	src_event_type events = '0;
	reg_req_type req = '0;
	logic [31:0] rdata;
	logic irq;
	logic [3:0] int_pin_out;
	logic [3:0] int_pin_oe;
	int errors = 0;
	int checks = 0;
	int cycles = 0;
	int i;
	pending_status_top #(.NUM_PINS(4)) u_pending_status_top (.clock(clock), .resetn(resetn),
		.sw_reset(sw_reset), .local_reset(local_reset), .events(events), .req(req), .rdata(rdata),
		.irq(irq), .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe));
	initial begin
		forever #4 clock = ~clock;
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clock);
		req <= '0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge clock);
		req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clock);
		req <= '0;
		#1;
		check("rdata", exp, rdata);
	endtask
	task automatic pulse(input logic [31:0] v);
		@(posedge clock);
		events <= v;
		@(posedge clock);
		events <= '0;
	endtask
	// Irq and pins lag two cycles, so settle three edges first
	task automatic pins(input logic [3:0] oe);
		repeat (3) @(posedge clock);
		#1;
		check("irq", {31'h0, |oe}, {31'h0, irq});
		check("pin_oe", {28'h0, oe}, {28'h0, int_pin_oe});
		check("pin_out", 32'h0, {28'h0, int_pin_out});
	endtask
	// Event and clear write in the same cycle, status read in the very next one; no idle cycle between strobes
	task automatic tight(input logic [31:0] ev, input logic [31:0] clr, input logic [31:0] exp);
		@(posedge clock);
		events <= ev;
		req <= '{12'h454, clr, 1'b1, 1'b0};
		@(posedge clock);
		events <= '0;
		req <= '{12'h450, 32'h0, 1'b0, 1'b1};
		@(posedge clock);
		req <= '0;
		#1;
		check("rdata", exp, rdata);
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ==========
	// Hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 4000) begin
			errors++;
			report_and_stop;
		end
	end
	// ==========
	// Sequence
	initial begin
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		rd(12'h450, 32'h0);
		for (i = 1; i < 26; i++) begin
			if ((32'h03ff3ffe >> i) & 32'h1) begin
				pulse(32'h1 << i);
				rd(12'h450, 32'h1 << i);
				wr(12'h454, 32'h1 << i);
				rd(12'h450, 32'h0);
			end
		end
		pulse(32'hfc00c001);
		rd(12'h450, 32'h0);
		pulse(32'hffffffff);
		wr(12'h450, 32'h0);
		wr(12'h454, 32'h0);
		rd(12'h450, 32'h03ff3ffe);
		rd(12'h450, 32'h03ff3ffe);
		rd(12'h454, 32'h0);
		rd(12'h460, 32'h0);
		wr(12'h454, 32'h03000000);
		rd(12'h450, 32'h00ff3ffe);
		wr(12'h44c, 32'h01000000);
		pins(4'h0);
		wr(12'h44c, 32'h01000002);
		rd(12'h44c, 32'h01000002);
		pins(4'h1);
		wr(12'h45c, 32'h3);
		rd(12'h45c, 32'h3);
		pins(4'h8);
		wr(12'h454, 32'h2);
		pins(4'h0);
		pulse(32'h01000000);
		pins(4'h1);
		for (i = 0; i < 2; i++) begin
			wr(12'h44c, 32'h2);
			pulse(32'h2);
			@(posedge clock);
			sw_reset <= (i == 0);
			local_reset <= (i == 1);
			@(posedge clock);
			sw_reset <= 1'b0;
			local_reset <= 1'b0;
			rd(12'h450, 32'h0);
			rd(12'h44c, 32'h0);
			pins(4'h0);
		end
		pulse(32'h2);
		@(posedge clock);
		resetn <= 1'b0;
		@(posedge clock);
		resetn <= 1'b1;
		rd(12'h450, 32'h0);
		tight(32'h02aa2aaa, 32'h0, 32'h02aa2aaa);
		tight(32'h2, 32'h03ff3ffe, 32'h2);
		report_and_stop;
	end
endmodule // interrupt_pending_status_test
